//--- logic/flb_pkg.sv
// constants shared by the framer loopback control block
package flb_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the avalon slave
	// ------------------------------------------------------------
	localparam logic [4:0] FLB_OFS_PRIMARY = 5'h00;
	localparam logic [4:0] FLB_OFS_SECONDARY = 5'h04;
	localparam logic [4:0] FLB_OFS_IDLE = 5'h08;
	localparam logic [4:0] FLB_OFS_OPTION = 5'h0C;
	localparam logic [4:0] FLB_OFS_STATUS = 5'h10;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FLB_ADDR_LSB = 0;
	localparam int FLB_ADDR_MSB = 4;
	localparam int FLB_PMODE_LSB = 5;
	localparam int FLB_PMODE_MSB = 7;
	localparam int FLB_SMODE_LSB = 5;
	localparam int FLB_SMODE_MSB = 6;
	localparam int FLB_SEC_RSVD_BIT = 7;
	localparam int FLB_OPT_E1_BIT = 0;
	localparam int FLB_OPT_EXT_BIT = 3;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] FLB_PRIMARY_RST = 8'h00;
	localparam logic [7:0] FLB_SECONDARY_RST = 8'h00;
	localparam logic [7:0] FLB_IDLE_RST = 8'h7F;
	localparam logic [7:0] FLB_OPTION_RST = 8'h00;

	// ------------------------------------------------------------
	// fixed codes
	// ------------------------------------------------------------
	localparam logic [7:0] FLB_AIS_BYTE = 8'hFF;
	localparam logic [4:0] FLB_SLOT_ZERO = 5'h00;

	typedef enum logic [2:0] {
		FLB_P_NONE = 3'h0,
		FLB_P_LINE = 3'h1,
		FLB_P_BOARD = 3'h2,
		FLB_P_SYS_SLOT = 3'h3,
		FLB_P_LINE_SLOT = 3'h4,
		FLB_P_BCAST = 3'h5,
		FLB_P_REGEN = 3'h6,
		FLB_P_PASS = 3'h7
	} flb_pmode_t;

	typedef enum logic [1:0] {
		FLB_S_NONE = 2'h0,
		FLB_S_SYS_SLOT = 2'h1,
		FLB_S_LINE_SLOT = 2'h2,
		FLB_S_RSVD = 2'h3
	} flb_smode_t;

	// true when the current slot is the addressed one
	function automatic logic flb_slot_hit(input logic [4:0] slot, input logic [4:0] addr);
		return slot == addr;
	endfunction

endpackage

//--- logic/flb_route.sv
// per-slot byte steering for the loopback modes
`timescale 1ns/1ps
module flb_route
	import flb_pkg::*;
(
	input wire logic [7:0] primary_loopback_reg,
	input wire logic [7:0] secondary_loopback_reg,
	input wire logic [7:0] line_idle_code_reg,
	input wire logic e1_mode,
	input wire logic ext_mode_select,
	input wire logic [4:0] slot,
	input wire logic [7:0] line_byte,
	input wire logic [7:0] sys_byte,
	input wire logic [7:0] bcast_hold,
	input wire logic [7:0] connect_hold,
	output logic [7:0] tx_line_next,
	output logic [7:0] sys_out_next,
	output logic regen_next,
	output logic dl_insert_next,
	output logic dl_in_crc_next,
	output logic sec_active
);
	import flb_pkg::*;

	flb_pmode_t primary_mode_code;
	flb_smode_t secondary_mode_code;
	logic [4:0] primary_slot_address;
	logic [4:0] secondary_slot_address;
	logic sec_blocked;

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	assign primary_mode_code = flb_pmode_t'(primary_loopback_reg[FLB_PMODE_MSB:FLB_PMODE_LSB]);
	assign primary_slot_address = primary_loopback_reg[FLB_ADDR_MSB:FLB_ADDR_LSB];
	assign secondary_mode_code = flb_smode_t'(secondary_loopback_reg[FLB_SMODE_MSB:FLB_SMODE_LSB]);
	assign secondary_slot_address = secondary_loopback_reg[FLB_ADDR_MSB:FLB_ADDR_LSB];

	// secondary only when primary is not a whole-stream loopback
	assign sec_blocked = (primary_mode_code == FLB_P_LINE) || (primary_mode_code == FLB_P_BOARD)
		|| (primary_mode_code == FLB_P_PASS)
		|| (primary_mode_code == FLB_P_REGEN && !ext_mode_select); // RL16
	// reserved code 11 acts as no loopback
	assign sec_active = !sec_blocked && (secondary_slot_address != primary_slot_address)
		&& (secondary_mode_code == FLB_S_SYS_SLOT
		|| secondary_mode_code == FLB_S_LINE_SLOT); // RL16 RL18 RL15

	// steering of both directions for the current slot
	always_comb begin
		tx_line_next = sys_byte;
		sys_out_next = line_byte;
		regen_next = 1'b0;
		dl_insert_next = 1'b0;
		dl_in_crc_next = 1'b0;
		unique case (primary_mode_code)
			FLB_P_NONE: begin
			end
			FLB_P_LINE: begin
				tx_line_next = line_byte; // RL2
			end
			FLB_P_BOARD: begin
				tx_line_next = FLB_AIS_BYTE; // RL3
				sys_out_next = sys_byte; // RL3
			end
			FLB_P_SYS_SLOT: begin
				if (flb_slot_hit(slot, primary_slot_address)) begin
					sys_out_next = sys_byte; // RL4
					tx_line_next = line_idle_code_reg; // RL4 RL17
				end
			end
			FLB_P_LINE_SLOT: begin
				if (flb_slot_hit(slot, primary_slot_address)) begin
					tx_line_next = line_byte; // RL5
					sys_out_next = line_idle_code_reg; // RL5 RL17
				end
			end
			FLB_P_BCAST: begin
				if (e1_mode && flb_slot_hit(slot, FLB_SLOT_ZERO)) begin
					tx_line_next = bcast_hold; // RL6
				end
			end
			FLB_P_REGEN: begin
				if (!ext_mode_select) begin
					// framer rebuilds framing, crc and whole slot 0 on e1
					tx_line_next = line_byte; // RL7
					regen_next = 1'b1; // RL7 RL8
					dl_insert_next = 1'b1; // RL7
				end else if (e1_mode && flb_slot_hit(slot, FLB_SLOT_ZERO)) begin
					sys_out_next = connect_hold; // RL10
				end
			end
			FLB_P_PASS: begin
				tx_line_next = line_byte; // RL11
				dl_insert_next = 1'b1; // RL11
				dl_in_crc_next = e1_mode; // RL12 RL13
			end
		endcase
		// the secondary loop never shares the primary slot
		if (sec_active && flb_slot_hit(slot, secondary_slot_address)) begin
			if (secondary_mode_code == FLB_S_SYS_SLOT) begin
				sys_out_next = sys_byte; // RL15
				tx_line_next = line_idle_code_reg; // RL15
			end else begin
				tx_line_next = line_byte; // RL15
				sys_out_next = line_idle_code_reg; // RL15
			end
		end
	end

endmodule

//--- logic/flb_loopback.sv
// framer loopback control: avalon registers and slot datapath
//
// Notes on behaviour
// RL1 - primary register: slot address bits 0-4, mode bits 5-7, resets to zero
// RL2 - mode 001 sends all received line data back to the line
// RL3 - mode 010 returns system data to system and sends AIS to line
// RL4 - mode 011 loops addressed slot on system side, idle code to line
// RL5 - mode 100 loops addressed slot line to line, idle code to system
// RL6 - mode 101 on E1 copies addressed slot also into slot 0
// RL7 - mode 110, select clear: payload to line, framing regenerated, system link inserted
// RL8 - regenerated mode on E1 rebuilds whole slot 0 in transmit framer
// RL9 - regenerated mode keeps receive framing and system delivery normal
// RL10 - mode 110, select set: addressed system slot returned in slot 0; the code does this on E1 only
// RL11 - mode 111 loops payload, CRC and framing, replaces data link bits
// RL12 - passthrough under ESF: inserted link bits leave CRC-6 unaffected
// RL13 - passthrough under E1: link bits count in CRC-4, remote sees errors
// RL14 - secondary register: address bits 0-4, mode 5-6, bit 7 zero
// RL15 - secondary codes: none, system slot, line slot, reserved
// RL16 - secondary acts only on another slot and no whole-stream loopback
// RL17 - idle code comes from an 8-bit register resetting to 7F
// RL18 - reserved secondary code behaves as no secondary loopback
`timescale 1ns/1ps
module flb_loopback
	import flb_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic slot_strobe,
	input wire logic [4:0] slot_num,
	input wire logic [7:0] line_rx_byte,
	input wire logic [7:0] sys_rx_byte,
	output logic out_strobe,
	output logic [4:0] out_slot,
	output logic [7:0] line_tx_byte,
	output logic [7:0] sys_tx_byte,
	output logic tx_regen_framing,
	output logic tx_dl_from_system,
	output logic tx_dl_in_crc
);
	import flb_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] primary_loopback_reg;
	logic [7:0] secondary_loopback_reg;
	logic [7:0] line_idle_code_reg;
	logic [7:0] framer_option_reg;
	logic [31:0] readdata_next;
	logic [7:0] status_byte;
	logic wr_take;
	logic sec_active;

	// a write with byteenable bit 0 set lands on the edge where waitrequest is seen low
	assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];

	// primary mode and address
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			primary_loopback_reg <= FLB_PRIMARY_RST; // RL1
		end else if (wr_take && avs_address == FLB_OFS_PRIMARY) begin
			primary_loopback_reg <= avs_writedata[7:0]; // RL1
		end
	end

	// secondary mode and address, reserved bit kept at zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			secondary_loopback_reg <= FLB_SECONDARY_RST; // RL14
		end else if (wr_take && avs_address == FLB_OFS_SECONDARY) begin
			secondary_loopback_reg <= {1'b0, avs_writedata[6:0]}; // RL14
		end
	end

	// programmable idle code
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			line_idle_code_reg <= FLB_IDLE_RST; // RL17
		end else if (wr_take && avs_address == FLB_OFS_IDLE) begin
			line_idle_code_reg <= avs_writedata[7:0]; // RL17
		end
	end

	// framing option: e1 select and external mode select
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			framer_option_reg <= FLB_OPTION_RST;
		end else if (wr_take && avs_address == FLB_OFS_OPTION) begin
			framer_option_reg <= avs_writedata[7:0];
		end
	end

	// status: secondary active and flags of the datapath
	assign status_byte = {3'h0, sec_active, tx_dl_in_crc, tx_dl_from_system,
		tx_regen_framing, out_strobe};

	// read mux, unmapped offsets read as zero
	always_comb begin
		readdata_next = 32'h0000_0000;
		unique case (avs_address)
			FLB_OFS_PRIMARY: readdata_next[7:0] = primary_loopback_reg;
			FLB_OFS_SECONDARY: readdata_next[7:0] = secondary_loopback_reg;
			FLB_OFS_IDLE: readdata_next[7:0] = line_idle_code_reg;
			FLB_OFS_OPTION: readdata_next[7:0] = framer_option_reg;
			FLB_OFS_STATUS: readdata_next[7:0] = status_byte;
			default: readdata_next = 32'h0000_0000;
		endcase
	end

	// one-cycle answer: waitrequest drops one cycle after the request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= readdata_next;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// slot held for slot 0 insertion
	// ------------------------------------------------------------
	logic [7:0] bcast_hold_reg;
	logic [7:0] connect_hold_reg;
	logic [4:0] primary_slot_address;

	assign primary_slot_address = primary_loopback_reg[FLB_ADDR_MSB:FLB_ADDR_LSB];

	// addressed system slot captured for the next frame's slot 0
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bcast_hold_reg <= 8'h00;
			connect_hold_reg <= 8'h00;
		end else if (slot_strobe && flb_slot_hit(slot_num, primary_slot_address)) begin
			bcast_hold_reg <= sys_rx_byte; // RL6
			connect_hold_reg <= sys_rx_byte; // RL10
		end
	end

	// ------------------------------------------------------------
	// steering and output stage
	// ------------------------------------------------------------
	logic [7:0] tx_line_next;
	logic [7:0] sys_out_next;
	logic regen_next;
	logic dl_insert_next;
	logic dl_in_crc_next;

	flb_route u_route (
		.primary_loopback_reg(primary_loopback_reg),
		.secondary_loopback_reg(secondary_loopback_reg),
		.line_idle_code_reg(line_idle_code_reg),
		.e1_mode(framer_option_reg[FLB_OPT_E1_BIT]),
		.ext_mode_select(framer_option_reg[FLB_OPT_EXT_BIT]),
		.slot(slot_num),
		.line_byte(line_rx_byte),
		.sys_byte(sys_rx_byte),
		.bcast_hold(bcast_hold_reg),
		.connect_hold(connect_hold_reg),
		.tx_line_next(tx_line_next),
		.sys_out_next(sys_out_next),
		.regen_next(regen_next),
		.dl_insert_next(dl_insert_next),
		.dl_in_crc_next(dl_in_crc_next),
		.sec_active(sec_active)
	);

	// byte outputs follow each slot strobe by one cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_strobe <= 1'b0;
			out_slot <= 5'h00;
			line_tx_byte <= 8'h00;
			sys_tx_byte <= 8'h00;
		end else begin
			out_strobe <= slot_strobe;
			if (slot_strobe) begin
				out_slot <= slot_num;
				line_tx_byte <= tx_line_next; // RL2 RL3 RL4 RL5 RL11
				sys_tx_byte <= sys_out_next; // RL9
			end
		end
	end

	// framing controls to the transmit framer, level per mode
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_regen_framing <= 1'b0;
			tx_dl_from_system <= 1'b0;
			tx_dl_in_crc <= 1'b0;
		end else begin
			tx_regen_framing <= regen_next; // RL7 RL8
			tx_dl_from_system <= dl_insert_next; // RL7 RL11
			tx_dl_in_crc <= dl_in_crc_next; // RL12 RL13
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [2:0] pmode;
	logic e1_on;
	logic ext_on;
	logic [4:0] sec_addr;
	logic [1:0] sec_code;

	assign pmode = primary_loopback_reg[FLB_PMODE_MSB:FLB_PMODE_LSB];
	assign e1_on = framer_option_reg[FLB_OPT_E1_BIT];
	assign ext_on = framer_option_reg[FLB_OPT_EXT_BIT];
	assign sec_addr = secondary_loopback_reg[FLB_ADDR_MSB:FLB_ADDR_LSB];
	assign sec_code = secondary_loopback_reg[FLB_SMODE_MSB:FLB_SMODE_LSB];

	sequence slot_in_mode(logic [2:0] m);
		slot_strobe && pmode == m;
	endsequence

	sequence slot_hit_in_mode(logic [2:0] m);
		slot_strobe && pmode == m && slot_num == primary_slot_address && !sec_active;
	endsequence

	// strobe on the live secondary slot with the given code
	sequence sec_hit_code(logic [1:0] c);
		slot_strobe && sec_active && slot_num == sec_addr && sec_code == c;
	endsequence

	// register values right after reset release
	reg_reset_a: assert property (@(posedge mclk) $rose(rst_n) |-> // RL1 RL14 RL17
		primary_loopback_reg == 8'h00 && secondary_loopback_reg == 8'h00
		&& line_idle_code_reg == 8'h7F)
		else $error("loopback registers not at reset values");

	// datapath checks, byte checks one cycle after each strobe, flag and gate checks every cycle
	line_return_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
		slot_in_mode(3'h1) |=> line_tx_byte == $past(line_rx_byte))
		else $error("line loopback did not return line byte");

	board_ais_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
		slot_in_mode(3'h2) |=> line_tx_byte == 8'hFF && sys_tx_byte == $past(sys_rx_byte))
		else $error("board loopback wrong bytes");

	sys_slot_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
		slot_hit_in_mode(3'h3) |=> line_tx_byte == $past(line_idle_code_reg)
		&& sys_tx_byte == $past(sys_rx_byte))
		else $error("system slot loopback wrong bytes");

	line_slot_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL5
		slot_hit_in_mode(3'h4) |=> line_tx_byte == $past(line_rx_byte)
		&& sys_tx_byte == $past(line_idle_code_reg))
		else $error("line slot loopback wrong bytes");

	bcast_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
		slot_in_mode(3'h5) ##0 (e1_on && slot_num == 5'h00 && !sec_active)
		|=> line_tx_byte == $past(bcast_hold_reg))
		else $error("broadcast slot 0 not copied");

	bcast_keep_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
		slot_hit_in_mode(3'h5) ##0 slot_num != 5'h00 |=> line_tx_byte == $past(sys_rx_byte))
		else $error("broadcast slot not sent in its own place");

	regen_flags_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL7 RL8
		pmode == 3'h6 && !ext_on |=> tx_regen_framing && tx_dl_from_system)
		else $error("regenerated loopback flags missing");

	regen_rx_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL9
		slot_in_mode(3'h6) ##0 !ext_on |=> sys_tx_byte == $past(line_rx_byte))
		else $error("receive path disturbed in regenerated loopback");

	connect_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
		slot_in_mode(3'h6) ##0 (ext_on && e1_on && slot_num == 5'h00 && !sec_active)
		|=> sys_tx_byte == $past(connect_hold_reg))
		else $error("connect loopback slot 0 wrong");

	pass_crc_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL11 RL12 RL13
		pmode == 3'h7 |=> tx_dl_from_system && !tx_regen_framing
		&& tx_dl_in_crc == $past(e1_on))
		else $error("passthrough loopback flags wrong");

	crc_only_pass_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL12 RL13
		pmode != 3'h7 |=> !tx_dl_in_crc)
		else $error("link bits counted in crc outside passthrough");

	sec_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL16 RL18
		sec_active |-> sec_addr != primary_slot_address
		&& pmode != 3'h1 && pmode != 3'h2 && pmode != 3'h7
		&& !(pmode == 3'h6 && !ext_on) && sec_code != 2'h0 && sec_code != 2'h3)
		else $error("secondary loopback active when it must not be");

	sec_sys_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL15
		sec_hit_code(2'h1) |=> sys_tx_byte == $past(sys_rx_byte)
		&& line_tx_byte == $past(line_idle_code_reg))
		else $error("secondary system slot loopback wrong bytes");

	sec_line_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL15
		sec_hit_code(2'h2) |=> line_tx_byte == $past(line_rx_byte)
		&& sys_tx_byte == $past(line_idle_code_reg))
		else $error("secondary line slot loopback wrong bytes");

	none_path_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
		slot_in_mode(3'h0) ##0 !sec_active |=> line_tx_byte == $past(sys_rx_byte)
		&& sys_tx_byte == $past(line_rx_byte))
		else $error("unlooped slot not passed straight through");

	strobe_follow_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL9
		slot_strobe |=> out_strobe && out_slot == $past(slot_num))
		else $error("slot answer not one cycle after strobe");

	// register and bus checks
	sec_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL14
		secondary_loopback_reg[FLB_SEC_RSVD_BIT] == 1'b0)
		else $error("secondary reserved bit set");

	wr_land_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
		wr_take && avs_address == FLB_OFS_PRIMARY
		|=> primary_loopback_reg == $past(avs_writedata[7:0]))
		else $error("primary write did not land");

	bus_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");

endmodule

//--- testbench/flb_partner.sv
// far-side model: line interface and system highway offering one slot at a time
`timescale 1ns/1ps
module flb_partner (
	input wire logic mclk,
	output logic slot_strobe,
	output logic [4:0] slot_num,
	output logic [7:0] line_rx_byte,
	output logic [7:0] sys_rx_byte
);
	// idle until the first slot is offered
	initial begin
		slot_strobe = 1'b0;
		slot_num = 5'h00;
		line_rx_byte = 8'h00;
		sys_rx_byte = 8'h00;
	end

	// one strobed slot, then the stale bytes are inverted so nothing reuses them
	task automatic offer(input logic [4:0] s, input logic [7:0] l, input logic [7:0] y);
		@(posedge mclk);
		slot_strobe <= 1'b1;
		slot_num <= s;
		line_rx_byte <= l;
		sys_rx_byte <= y;
		@(posedge mclk);
		slot_strobe <= 1'b0;
		slot_num <= ~s;
		line_rx_byte <= ~l;
		sys_rx_byte <= ~y;
	endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the loopback control block
`timescale 1ns/1ps
module testbench;
	import flb_pkg::*;

	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic slot_strobe, out_strobe, tx_regen_framing, tx_dl_from_system, tx_dl_in_crc;
	logic [4:0] slot_num, out_slot;
	logic [7:0] line_rx_byte, sys_rx_byte, line_tx_byte, sys_tx_byte;
	int error_cnt = 0;
	int check_count = 0;
	logic [7:0] pri, sec, idl, opt, held;
	logic [31:0] q;

	flb_loopback u_flb_loopback (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .slot_strobe(slot_strobe), .slot_num(slot_num),
		.line_rx_byte(line_rx_byte), .sys_rx_byte(sys_rx_byte), .out_strobe(out_strobe),
		.out_slot(out_slot), .line_tx_byte(line_tx_byte), .sys_tx_byte(sys_tx_byte),
		.tx_regen_framing(tx_regen_framing), .tx_dl_from_system(tx_dl_from_system),
		.tx_dl_in_crc(tx_dl_in_crc));

	flb_partner u_flb_partner (.mclk(mclk), .slot_strobe(slot_strobe), .slot_num(slot_num),
		.line_rx_byte(line_rx_byte), .sys_rx_byte(sys_rx_byte));

	// 100 ns clock
	initial begin
		forever #50 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------
	task automatic finish_test;
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// hang guard, far beyond the expected run
	initial begin
		#3000000;
		error_cnt++;
		finish_test;
	end

	// ------------------------------------------------------------
	// avalon master: hold request until waitrequest seen low
	// ------------------------------------------------------------
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		// only the watchdog ends a wait that never sees waitrequest low
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// reference copy of what a landed write stores
		if (wr && be[0]) begin
			case (a)
				FLB_OFS_PRIMARY: pri = d;
				FLB_OFS_SECONDARY: sec = {1'b0, d[6:0]};
				FLB_OFS_IDLE: idl = d;
				FLB_OFS_OPTION: opt = d;
				default: ;
			endcase
		end
	endtask

	// ------------------------------------------------------------
	// reference steering of one slot
	// ------------------------------------------------------------
	function automatic logic [15:0] expect_bytes(input logic [4:0] s, input logic [7:0] l,
		input logic [7:0] y);
		logic [2:0] m;
		logic [7:0] lt, st;
		logic blk;
		m = pri[7:5];
		lt = y;
		st = l;
		case (m)
			3'h1: lt = l;
			3'h2: begin
				lt = 8'hFF;
				st = y;
			end
			3'h3: if (s == pri[4:0]) begin
				st = y;
				lt = idl;
			end
			3'h4: if (s == pri[4:0]) begin
				lt = l;
				st = idl;
			end
			3'h5: if (opt[0] && s == 5'h00) lt = held;
			3'h6: if (!opt[3]) lt = l; else if (opt[0] && s == 5'h00) st = held;
			3'h7: lt = l;
			default: ;
		endcase
		blk = (m == 3'h1) || (m == 3'h2) || (m == 3'h7) || (m == 3'h6 && !opt[3]);
		if (!blk && sec[4:0] != pri[4:0] && s == sec[4:0]) begin
			if (sec[6:5] == 2'h1) begin
				st = y;
				lt = idl;
			end else if (sec[6:5] == 2'h2) begin
				lt = l;
				st = idl;
			end
		end
		return {lt, st};
	endfunction

	// offer a slot and compare the registered answer
	task automatic run_slot(input logic [4:0] s);
		logic [7:0] l, y;
		logic [15:0] e;
		l = 8'($urandom);
		y = 8'($urandom);
		e = expect_bytes(s, l, y);
		if (s == pri[4:0]) held = y;
		u_flb_partner.offer(s, l, y);
		#1;
		chk({31'h0, out_strobe}, 32'h1);
		chk({27'h0, out_slot}, {27'h0, s});
		chk({24'h0, line_tx_byte}, {24'h0, e[15:8]});
		chk({24'h0, sys_tx_byte}, {24'h0, e[7:0]});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [2:0] m;
		logic [4:0] pa, sa;
		logic blk;
		pri = 8'h00;
		sec = 8'h00;
		idl = 8'h7F;
		opt = 8'h00;
		held = 8'h00;
		void'($urandom(32'h8955));
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// reset values and access kinds
		bus(1'b0, FLB_OFS_PRIMARY, 8'h00, 4'hF, q);
		chk(q, 32'h00);
		bus(1'b0, FLB_OFS_SECONDARY, 8'h00, 4'hF, q);
		chk(q, 32'h00);
		bus(1'b0, FLB_OFS_IDLE, 8'h00, 4'hF, q);
		chk(q, 32'h7F);
		bus(1'b1, FLB_OFS_PRIMARY, 8'hA5, 4'hE, q);
		bus(1'b0, FLB_OFS_PRIMARY, 8'h00, 4'hF, q);
		chk(q, 32'h00);
		bus(1'b1, FLB_OFS_SECONDARY, 8'hFF, 4'hF, q);
		bus(1'b0, FLB_OFS_SECONDARY, 8'h00, 4'hF, q);
		chk(q, 32'h7F);
		bus(1'b0, 5'h14, 8'h00, 4'hF, q);
		chk(q, 32'h00);
		bus(1'b1, FLB_OFS_STATUS, 8'hFF, 4'hF, q);
		bus(1'b0, FLB_OFS_STATUS, 8'h00, 4'hF, q);
		chk(q, 32'h00);
		// every primary mode against every secondary code, both framings and selects
		for (int k = 0; k < 128; k++) begin
			m = k[2:0];
			pa = 5'(1 + $urandom % 31);
			sa = (k % 3 == 0) ? pa : 5'(1 + $urandom % 31);
			bus(1'b1, FLB_OFS_OPTION, {4'($urandom), k[3], 2'($urandom), k[4]}, 4'hF, q);
			bus(1'b1, FLB_OFS_IDLE, 8'($urandom), 4'hF, q);
			bus(1'b1, FLB_OFS_PRIMARY, {m, pa}, 4'hF, q);
			bus(1'b1, FLB_OFS_SECONDARY, {1'b0, k[6:5], sa}, 4'hF, q);
			bus(1'b0, FLB_OFS_PRIMARY, 8'h00, 4'hF, q);
			chk(q, {24'h0, pri});
			bus(1'b0, FLB_OFS_STATUS, 8'h00, 4'hF, q);
			blk = m == 3'h1 || m == 3'h2 || m == 3'h7 || (m == 3'h6 && !opt[3]);
			chk({27'h0, q[4:1], 1'b0}, {27'h0, !blk && sa != pa && (k[6:5] == 2'h1
				|| k[6:5] == 2'h2), m == 3'h7 && opt[0], m == 3'h7 || (m == 3'h6 && !opt[3]),
				m == 3'h6 && !opt[3], 1'b0});
			run_slot(pa);
			run_slot(5'h00);
			run_slot(sa);
			run_slot(5'($urandom));
			chk({29'h0, tx_regen_framing, tx_dl_from_system, tx_dl_in_crc},
				{29'h0, m == 3'h6 && !opt[3], m == 3'h7 || (m == 3'h6 && !opt[3]),
				m == 3'h7 && opt[0]});
		end
		finish_test;
	end
endmodule
